//--- hdl/clk_startup_params.svh
// Constants for the clock source and start-up delay block
//
// Functional notes
// - Low-frequency crystal wake waits 1K cycles with low bit 0, 32K with 1.
// - Low-frequency crystal reset delay: 14 cycles, plus 4.1 ms or 65 ms; 11 reserved.
// - Source 0010 picks the calibrated 8 MHz RC oscillator.
// - Factory default source is the calibrated RC oscillator.
// - Every reset copies the factory calibration byte into the RC trim register.
// - Software may rewrite the RC trim register at run time.
// - Watchdog oscillator still times reset time-out when RC is system clock.
// - RC source: wake 6 cycles; reset 14 cycles, plus 4.1 or 65 ms; 11 reserved.
// - Factory default start-up field for RC is slowly rising power, 10.
// - Source 0011 picks the 128 kHz low-power oscillator.
// - 128 kHz source: wake 6 cycles; reset 14 cycles, plus 4 or 64 ms.
// - Source 0000 takes the clock from the crystal input pin.
// - External clock: wake 6 cycles; reset 14 cycles, plus 4.1 or 65 ms.
// - Factory default enables the divide-by-eight start-up option.
// - Reset loads prescale 0011 with divide-by-eight on, else 0000.
`ifndef CLK_STARTUP_PARAMS_SVH
`define CLK_STARTUP_PARAMS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ADDR_CONFIG          8'h00
`define ADDR_TRIM            8'h04
`define ADDR_PRESCALE        8'h08
`define ADDR_CONTROL         8'h0C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CFG_SRC_LSB          0
`define CFG_SRC_MSB          3
`define CFG_SUT_LSB          4
`define CFG_SUT_MSB          5
`define CFG_DIV8_BIT         6
`define CTL_RESTART_BIT      0
`define CTL_SLEEP_BIT        1
`define CTL_WAKE_BIT         2

// ----------------------------------------
// Option encodings and reset values
// ----------------------------------------
`define SRC_EXTERNAL         4'h0
`define SRC_RC               4'h2
`define SRC_LP128            4'h3
`define SRC_LF_XTAL_HI       3'h2
`define SUT_BOD              2'h0
`define SUT_FAST             2'h1
`define SUT_SLOW             2'h2
`define SUT_RESERVED         2'h3
`define DEF_SRC              4'h2
`define DEF_SUT              2'h2
`define DEF_DIV8             1'b1
`define PRESCALE_DIV8        4'h3
`define PRESCALE_DIV1        4'h0

// ----------------------------------------
// Timing: source cycles, times in us, watchdog rate
// ----------------------------------------
`define RESET_CK             17'h0000E
`define WAKE_INT_CK          17'h00006
`define WAKE_LF_SHORT_CK     17'h00400
`define WAKE_LF_LONG_CK      32768
`define WDT_FREQ_KHZ         128
`define T_FAST_US            4100
`define T_SLOW_US            65000
`define T_FAST128_US         4000
`define T_SLOW128_US         64000

`endif

//--- hdl/clk_startup_pkg.sv
// Types shared by the clock source and start-up delay block
package clk_startup_pkg;

	// Start-up sequencer states, one-hot
	typedef enum logic [6:0] {
		ST_LOAD   = 7'h01,
		ST_RST_CK = 7'h02,
		ST_RST_MS = 7'h04,
		ST_RUN    = 7'h08,
		ST_SLEEP  = 7'h10,
		ST_WAKE   = 7'h20,
		ST_HALT   = 7'h40
	} state_e;

	typedef logic [3:0]  src_sel_t;
	typedef logic [1:0]  sut_t;
	typedef logic [16:0] count_t;

endpackage

//--- hdl/rise_detect.sv
// Rising edge detector for oscillator levels sampled on pclk
`timescale 1ns/1ns
`default_nettype none

module rise_detect #(
	parameter int WIDTH = 5
) (
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Levels and edge pulses
	input  wire logic [WIDTH-1:0] level,
	output logic      [WIDTH-1:0] rise
);

	logic [WIDTH-1:0] level_q;

	// Previous sample
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			level_q <= '0;
		end else begin
			level_q <= level;
		end
	end

	// One pclk pulse per rising edge
	assign rise = level & ~level_q;

endmodule

`default_nettype wire

//--- hdl/tick_counter.sv
// Counts tick pulses up to a target after a start pulse
`timescale 1ns/1ns
`default_nettype none

module tick_counter #(
	parameter int W = 17
) (
	// Clock and reset
	input  wire logic         pclk,
	input  wire logic         presetn,
	// Control
	input  wire logic         start,
	input  wire logic         tick,
	input  wire logic [W-1:0] target,
	// Result
	output logic              done,
	output logic      [W-1:0] count
);

	// Restart at zero, then step on each tick until the target is met
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (start) begin
			count <= '0;
		end else if (tick && !done) begin
			count <= count + 1'b1;
		end
	end

	assign done = (count >= target);

endmodule

`default_nettype wire

//--- hdl/clock_source_startup_select.sv
// Clock source selection, start-up delay and trim/prescale load, APB slave
`timescale 1ns/1ns
`default_nettype none
`include "clk_startup_params.svh"

module clock_source_startup_select #(
	parameter int WAKE_LF_LONG_CK = `WAKE_LF_LONG_CK,
	parameter int SLOW_WDT_CK     = (`T_SLOW_US * `WDT_FREQ_KHZ + 999) / 1000,
	parameter int SLOW128_WDT_CK  = (`T_SLOW128_US * `WDT_FREQ_KHZ + 999) / 1000
) (
	// Clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// APB slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic                          pready,
	output logic      [31:0]              prdata,
	output logic                          pslverr,
	// Oscillator levels, sampled on pclk
	input  wire logic                     lf_xtal_osc,
	input  wire logic                     rc_osc,
	input  wire logic                     lp128_osc,
	input  wire logic                     crystal_input_pin,
	input  wire logic                     watchdog_osc,
	// Factory calibration and wake
	input  wire logic [7:0]               calibration_byte,
	input  wire logic                     deep_sleep_wake,
	// Clock control outputs
	output logic                          system_clock_enable,
	output clk_startup_pkg::src_sel_t     active_source,
	output logic                          rc_osc_enable,
	output logic      [7:0]               rc_trim,
	output logic      [3:0]               prescale
);

	import clk_startup_pkg::*;

	// ----------------------------------------
	// Derived delay targets
	// ----------------------------------------
	localparam count_t FAST_WDT    = count_t'((`T_FAST_US * `WDT_FREQ_KHZ + 999) / 1000);
	localparam count_t FAST128_WDT = count_t'((`T_FAST128_US * `WDT_FREQ_KHZ + 999) / 1000);
	localparam count_t SLOW_WDT    = count_t'(SLOW_WDT_CK);
	localparam count_t SLOW128_WDT = count_t'(SLOW128_WDT_CK);
	localparam count_t WAKE_LONG   = count_t'(WAKE_LF_LONG_CK);

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	state_e    state;
	state_e    next_state;
	src_sel_t  cfg_source;
	sut_t      cfg_sut;
	logic      cfg_div8;
	sut_t      active_sut;
	count_t    target;
	count_t    next_target;
	logic      count_start;
	logic      count_done;
	logic      count_tick;
	count_t    count_value;
	logic      src_tick;
	logic [4:0] osc_rise;
	logic      lf_source;
	logic      source_ok;
	logic      wr_en;
	logic      rd_phase;
	logic      restart_req;
	logic      sleep_req;
	logic      wake_req;
	logic      addr_hit;
	logic [31:0] rd_mux;

	// ----------------------------------------
	// Oscillator edge detection and counter
	// ----------------------------------------
	rise_detect #(
		.WIDTH (5)
	) u_rise (
		.pclk    (pclk),
		.presetn (presetn),
		.level   ({watchdog_osc, crystal_input_pin, lp128_osc, rc_osc, lf_xtal_osc}),
		.rise    (osc_rise)
	);

	tick_counter #(
		.W (17)
	) u_count (
		.pclk    (pclk),
		.presetn (presetn),
		.start   (count_start),
		.tick    (count_tick),
		.target  (target),
		.done    (count_done),
		.count   (count_value)
	);

	// Edge of the selected source
	always_comb begin
		lf_source = (active_source[3:1] == `SRC_LF_XTAL_HI);
		src_tick  = 1'b0;
		source_ok = 1'b1;
		if (lf_source) begin
			src_tick = osc_rise[0];
		end else begin
			case (active_source)
				`SRC_RC:       src_tick = osc_rise[1];
				`SRC_LP128:    src_tick = osc_rise[2];
				`SRC_EXTERNAL: src_tick = osc_rise[3];
				default:       source_ok = 1'b0;
			endcase
		end
	end

	// Millisecond phase always runs on the watchdog oscillator
	assign count_tick = (state == ST_RST_MS) ? osc_rise[4] : src_tick;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign wr_en       = psel && penable && pready && pwrite && addr_hit;
	assign rd_phase    = psel && penable && !pready;
	assign restart_req = wr_en && (paddr == `ADDR_CONTROL) && pwdata[`CTL_RESTART_BIT];
	assign sleep_req   = wr_en && (paddr == `ADDR_CONTROL) && pwdata[`CTL_SLEEP_BIT];
	assign wake_req    = deep_sleep_wake || (wr_en && (paddr == `ADDR_CONTROL) && pwdata[`CTL_WAKE_BIT]);

	// Mapped offsets and read data
	always_comb begin
		addr_hit = 1'b1;
		rd_mux   = 32'h00000000;
		case (paddr)
			`ADDR_CONFIG:   rd_mux[6:0] = {cfg_div8, cfg_sut, cfg_source};
			`ADDR_TRIM:     rd_mux[7:0] = rc_trim;
			`ADDR_PRESCALE: rd_mux[3:0] = prescale;
			`ADDR_CONTROL:  rd_mux[3:0] = {state == ST_SLEEP, state == ST_HALT,
				(state == ST_RST_CK) || (state == ST_RST_MS) || (state == ST_LOAD), system_clock_enable};
			default:        addr_hit = 1'b0;
		endcase
	end

	// One wait state, then registered answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= rd_phase;
			pslverr <= rd_phase && !addr_hit;
			// Unmapped accesses of either direction answer with zero data
			if (rd_phase && (!pwrite || !addr_hit)) begin
				prdata <= rd_mux;
			end
		end
	end

	// ----------------------------------------
	// Option register, factory defaults
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_source <= `DEF_SRC;
			cfg_sut    <= `DEF_SUT;
			cfg_div8   <= `DEF_DIV8;
		end else if (wr_en && (paddr == `ADDR_CONFIG)) begin
			cfg_source <= pwdata[`CFG_SRC_MSB:`CFG_SRC_LSB];
			cfg_sut    <= pwdata[`CFG_SUT_MSB:`CFG_SUT_LSB];
			cfg_div8   <= pwdata[`CFG_DIV8_BIT];
		end
	end

	// ----------------------------------------
	// Trim and prescale, loaded on every restart
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rc_trim <= 8'h00;
		end else if (state == ST_LOAD) begin
			rc_trim <= calibration_byte;
		end else if (wr_en && (paddr == `ADDR_TRIM)) begin
			rc_trim <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prescale <= `PRESCALE_DIV1;
		end else if (state == ST_LOAD) begin
			prescale <= cfg_div8 ? `PRESCALE_DIV8 : `PRESCALE_DIV1;
		end else if (wr_en && (paddr == `ADDR_PRESCALE)) begin
			prescale <= pwdata[3:0];
		end
	end

	// Options latched for the running sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_source <= `DEF_SRC;
			active_sut    <= `DEF_SUT;
		end else if (state == ST_LOAD) begin
			active_source <= cfg_source;
			active_sut    <= cfg_sut;
		end
	end

	// ----------------------------------------
	// Start-up sequencer
	// ----------------------------------------
	always_comb begin
		next_state  = state;
		next_target = target;
		count_start = 1'b0;
		case (state)
			ST_LOAD: begin
				next_state = ST_RST_CK;
			end
			ST_RST_CK: begin
				if (!source_ok || (active_sut == `SUT_RESERVED)) begin
					next_state = ST_HALT;
				end else if (count_done) begin
					// Cycle part done, now the millisecond part
					count_start = 1'b1;
					case (active_sut)
						`SUT_FAST: next_target = (active_source == `SRC_LP128) ? FAST128_WDT : FAST_WDT;
						`SUT_SLOW: next_target = (active_source == `SRC_LP128) ? SLOW128_WDT : SLOW_WDT;
						default:   next_target = '0;
					endcase
					next_state = (active_sut == `SUT_BOD) ? ST_RUN : ST_RST_MS;
				end
			end
			ST_RST_MS: begin
				if (count_done) begin
					next_state = ST_RUN;
				end
			end
			ST_RUN: begin
				if (sleep_req) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (wake_req) begin
					count_start = 1'b1;
					if (lf_source) begin
						next_target = active_source[0] ? WAKE_LONG : `WAKE_LF_SHORT_CK;
					end else begin
						next_target = `WAKE_INT_CK;
					end
					next_state = ST_WAKE;
				end
			end
			ST_WAKE: begin
				if (count_done) begin
					next_state = ST_RUN;
				end
			end
			ST_HALT: begin
				next_state = ST_HALT;
			end
			default: begin
				next_state = ST_LOAD;
			end
		endcase
		// Software restart replays the whole reset sequence
		if (restart_req) begin
			next_state = ST_LOAD;
		end
		// Entering the cycle phase arms the 14-cycle count
		if (next_state == ST_RST_CK && state != ST_RST_CK) begin
			count_start = 1'b1;
			next_target = `RESET_CK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state  <= ST_LOAD;
			target <= `RESET_CK;
		end else begin
			state  <= next_state;
			target <= next_target;
		end
	end

	// ----------------------------------------
	// Clock gate and oscillator enable
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_clock_enable <= 1'b0;
			rc_osc_enable       <= 1'b0;
		end else begin
			system_clock_enable <= (next_state == ST_RUN);
			// Follows the source being latched, so it never lags a source change
			rc_osc_enable       <= (((state == ST_LOAD) ? cfg_source : active_source) == `SRC_RC)
				&& (next_state != ST_HALT);
		end
	end

endmodule

`default_nettype wire

//--- dv/clock_source_startup_select_props.sv
// Assertion checker for the clock source start-up block
`timescale 1ns/1ns
`default_nettype none

module clock_source_startup_select_props
	import clk_startup_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// APB
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// Oscillators and trim source
	input wire logic        lf_xtal_osc,
	input wire logic        rc_osc,
	input wire logic        lp128_osc,
	input wire logic        crystal_input_pin,
	input wire logic [7:0]  calibration_byte,
	// Clock control
	input wire logic        system_clock_enable,
	input wire src_sel_t    active_source,
	input wire logic        rc_osc_enable,
	input wire logic [7:0]  rc_trim,
	input wire logic [3:0]  prescale
);
	logic       up;
	logic       lvl;
	logic       lvl_q;
	logic [5:0] edges;
	logic       ctl_wr;

	// Control register write on the bus
	assign ctl_wr = psel && pwrite && paddr == 8'h0C;

	// Level of the oscillator behind the active source
	always_comb begin
		case (active_source)
			4'h0:    lvl = crystal_input_pin;
			4'h2:    lvl = rc_osc;
			4'h3:    lvl = lp128_osc;
			default: lvl = lf_xtal_osc;
		endcase
	end

	// First edge after release; source rises seen while gated
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			up    <= 1'b0;
			lvl_q <= 1'b0;
			edges <= 6'h00;
		end else begin
			up    <= 1'b1;
			lvl_q <= lvl;
			if (system_clock_enable)
				edges <= 6'h00;
			else if (lvl && !lvl_q && edges != 6'h3F)
				edges <= edges + 6'h01;
		end
	end

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_pready_single: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_access_answer: assert property (psel && penable && !pready |=> pready)
		else $error("access phase not answered after one wait");
	a_error_empty: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error response without pready or with data");
	a_trim_loaded: assert property (!up |=> rc_trim == $past(calibration_byte))
		else $error("trim not loaded after reset");
	a_prescale_loaded: assert property (!up |=> prescale == 4'h3)
		else $error("prescale not divide by eight after reset");
	a_source_default: assert property (!up |=> active_source == 4'h2)
		else $error("default source not the RC oscillator");
	a_rc_enable_src: assert property (rc_osc_enable |-> active_source == 4'h2)
		else $error("RC enabled while another source active");
	a_gate_count: assert property ($rose(system_clock_enable) |-> edges >= 6'h06)
		else $error("clock ungated before enough source cycles");
	a_enable_drop: assert property ($fell(system_clock_enable) |-> $past(ctl_wr, 1) || $past(ctl_wr, 2))
		else $error("clock gated without a control write");
endmodule

bind clock_source_startup_select clock_source_startup_select_props u_props (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready, .prdata, .pslverr,
	.lf_xtal_osc, .rc_osc, .lp128_osc, .crystal_input_pin, .calibration_byte,
	.system_clock_enable, .active_source, .rc_osc_enable, .rc_trim, .prescale
);
`default_nettype wire

//--- dv/osc_model.sv
// Free-running oscillator models feeding the clock block
`timescale 1ns/1ns
`default_nettype none

module osc_model (
	// Clock
	input  wire logic pclk,
	// Oscillator levels
	output logic      lf_xtal_osc,
	output logic      rc_osc,
	output logic      lp128_osc,
	output logic      crystal_input_pin,
	output logic      watchdog_osc
);
	int         half [5] = '{1, 4, 3, 2, 5};
	int         cnt [5]  = '{0, 0, 0, 0, 0};
	logic [4:0] lvl      = 5'h00;

	// Fixed periods, never stepped, so no reset hold is needed
	always @(posedge pclk) begin
		for (int i = 0; i < 5; i++) begin
			cnt[i] = cnt[i] + 1;
			if (cnt[i] == half[i]) begin
				cnt[i] = 0;
				lvl[i] <= ~lvl[i];
			end
		end
	end
	assign {lf_xtal_osc, rc_osc, lp128_osc, crystal_input_pin, watchdog_osc} = lvl;
endmodule
`default_nettype wire

//--- dv/clock_source_startup_select_bench.sv
// Self-checking bench for the clock source start-up block
`timescale 1ns/1ns
`default_nettype none

module clock_source_startup_select_bench;
	import clk_startup_pkg::*;

	localparam int WP = 2; // Watchdog period in pclk cycles
	logic        pclk             = 1'b0;
	logic        presetn          = 1'b0;
	logic        psel             = 1'b0;
	logic        penable          = 1'b0;
	logic        pwrite           = 1'b0;
	logic [7:0]  paddr            = 8'h00;
	logic [31:0] pwdata           = 32'h0;
	logic [31:0] rnd              = 32'hC763DB46;
	logic [7:0]  calibration_byte = 8'h46;
	logic        deep_sleep_wake  = 1'b0;
	logic        pready, pslverr, e, system_clock_enable, rc_osc_enable;
	logic        lf_xtal_osc, rc_osc, lp128_osc, crystal_input_pin, watchdog_osc;
	logic [31:0] prdata, r;
	src_sel_t    active_source;
	logic [7:0]  rc_trim;
	logic [3:0]  prescale;
	int          n_fail   = 0;
	int          compares = 0;
	logic [3:0]  src_tab [7] = '{4'h0, 4'h0, 4'h3, 4'h3, 4'h2, 4'h4, 4'h5};
	logic [1:0]  sut_tab [7] = '{2'h0, 2'h1, 2'h2, 2'h1, 2'h0, 2'h2, 2'h0};

	clock_source_startup_select #(.WAKE_LF_LONG_CK(40), .SLOW_WDT_CK(20), .SLOW128_WDT_CK(20))
	u_clock_source_startup_select (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
		.lf_xtal_osc, .rc_osc, .lp128_osc, .crystal_input_pin, .watchdog_osc, .calibration_byte,
		.deep_sleep_wake, .system_clock_enable, .active_source, .rc_osc_enable, .rc_trim, .prescale
	);
	osc_model u_osc_model (.pclk, .lf_xtal_osc, .rc_osc, .lp128_osc, .crystal_input_pin, .watchdog_osc);

	always #5 pclk = ~pclk;

	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	// Source period in pclk cycles, as the oscillator model runs it
	function automatic int per(input logic [3:0] s);
		return s == 4'h0 ? 8 : s == 4'h2 ? 4 : s == 4'h3 ? 6 : 10;
	endfunction

	// Restart to ungate: 14 source cycles, then the watchdog part
	function automatic int rst_cyc(input logic [3:0] s, input logic [1:0] u);
		int ms;
		ms = u == 2'h0 ? 0 : u == 2'h2 ? 20 : s == 4'h3 ? 512 : 525;
		return 14 * per(s) + ms * WP;
	endfunction

	function automatic int wake_cyc(input logic [3:0] s);
		return (s[3:1] == 3'h2 ? (s[0] ? 40 : 1024) : 6) * per(s);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer, released one idle edge later
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		chk(k < 50, 1);
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Waits for ungating and checks the cycle count against the model
	task automatic wait_en(input int ex, input int p);
		int n;
		n = 0;
		while (system_clock_enable !== 1'b1 && n < ex + p + WP + 9) begin
			@(posedge pclk);
			n++;
		end
		chk(n >= ex - p - WP && n <= ex + p + WP + 8, 1);
	endtask

	task automatic finish_test;
		if (n_fail == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(rc_trim, 8'h46);
		chk(prescale, 4'h3);
		chk(active_source, 4'h2);
		apb(1'b0, 8'h00, 32'h0);
		chk(r, 32'h62);
		wait_en(rst_cyc(4'h2, 2'h2) - 6, 4);
		apb(1'b0, 8'h10, 32'h0);
		chk(e, 1'b1);
		chk(r, 32'h0);
		rnd = lfsr(rnd);
		apb(1'b1, 8'h04, rnd);
		apb(1'b0, 8'h04, 32'h0);
		chk(r, {24'h0, rnd[7:0]});
		chk(rc_trim, rnd[7:0]);
		apb(1'b1, 8'h08, rnd);
		apb(1'b0, 8'h08, 32'h0);
		chk(r, {28'h0, rnd[3:0]});
		chk(prescale, rnd[3:0]);
		// Every source and each non-reserved start-up field, then sleep and wake
		for (int i = 0; i < 7; i++) begin
			rnd = lfsr(rnd);
			calibration_byte <= rnd[7:0];
			apb(1'b1, 8'h00, {25'h0, i[0], sut_tab[i], src_tab[i]});
			apb(1'b1, 8'h0C, 32'h1);
			wait_en(rst_cyc(src_tab[i], sut_tab[i]), per(src_tab[i]));
			chk(prescale, i[0] ? 4'h3 : 4'h0);
			chk(rc_trim, rnd[7:0]);
			chk(active_source, src_tab[i]);
			chk(rc_osc_enable, src_tab[i] == 4'h2);
			apb(1'b1, 8'h0C, 32'h2);
			repeat (2) @(posedge pclk);
			chk(system_clock_enable, 1'b0);
			apb(1'b0, 8'h0C, 32'h0);
			chk(r[3:0], 4'h8);
			// Wake by control write on some passes, by the wake pin on others
			if (i[1]) begin
				apb(1'b1, 8'h0C, 32'h4);
			end else begin
				deep_sleep_wake <= 1'b1;
				@(posedge pclk);
				deep_sleep_wake <= 1'b0;
			end
			wait_en(wake_cyc(src_tab[i]), per(src_tab[i]));
		end
		// Reserved start-up field halts sources 0000, 0011, 0010 and 0101
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h00, {26'h0, 2'h3, src_tab[2 * i]});
			apb(1'b1, 8'h0C, 32'h1);
			repeat (300) @(posedge pclk);
			chk(system_clock_enable, 1'b0);
			apb(1'b0, 8'h0C, 32'h0);
			chk(r[2], 1'b1);
		end
		// Second reset in mid-run restores the defaults
		presetn          <= 1'b0;
		calibration_byte <= 8'hC3;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk(rc_trim, 8'hC3);
		chk({active_source, prescale}, 8'h23);
		wait_en(rst_cyc(4'h2, 2'h2) - 2, 4);
		finish_test();
	end

	// Hang guard, about two and a half times the expected run of some 16k cycles
	initial begin
		#400000;
		n_fail++;
		finish_test();
	end
endmodule
`default_nettype wire
